// file: logic/usb_func_regs.sv
// Register block of a USB 2.0 function: interrupt enables, bus-event flags, frame number,
// test modes, endpoint select, IN max payload, IN control high byte and endpoint 0 control.
// Assumes the packet engine presents its events as one-cycle pulses on CORE_CLK and that the
// CPU port gives single-cycle read and write strobes; read data appears one cycle later.

// Operation
// - OUT enable: endpoint 2 at bit 2, endpoint 1 at bit 1, reset 06h.
// - Bus enable: frame start 3, bus reset 2, resume 1, sleep 0, reset 06h.
// - Bus pending flags same layout; reading the register clears all flags.
// - Last received 11-bit frame number: high three bits and low byte, read only.
// - Bus reset picks full speed when forced full, high speed when forced high.
// - Test packet mode repeatedly sends 53-byte endpoint 0 packet at high speed.
// - Test K drives continuous K, test J continuous J, at high speed.
// - Zero-NAK test keeps high speed and NAKs every valid IN token.
// - Select field maps endpoint 0, 1, 2 or none into the 10h-19h window.
// - IN endpoints 1 and 2 each hold an 11-bit max payload, high and low.
// - Auto commit raises in-ready on full packet; endpoint 0 high control reads 00h.
// - DMA enable bit passes or blocks DMA requests of the IN endpoint.
// - Force toggle flips IN data toggle after every packet, ACK or not.
// - Early finish flag sets, interrupts, flushes; write 1 bit 7 clears it.
// - Send stall written by software is cleared after the STALL is sent.
// - Software sets data end; device clears it when the transfer ends.
// - Stall sent flag set on each STALL; software clears it.
// - Software sets in-ready; device clears it after sending and interrupts.
// - Out-ready set on reception with interrupt; write 1 bit 6 clears it.
module usb_func_regs (
    input  wire logic                               CORE_CLK,
    input  wire logic                               RST_N,
    input  wire logic [5:0]                         REG_ADDR,
    input  wire logic                               REG_WR,
    input  wire logic                               REG_RD,
    input  wire logic [7:0]                         REG_WDATA,
    output logic [7:0]                              REG_RDATA,
    input  wire logic                               FRAME_START_SEEN,
    input  wire logic [10:0]                        FRAME_NUMBER_IN,
    input  wire logic                               BUS_RESET_SEEN,
    input  wire logic                               RESUME_SEEN,
    input  wire logic                               SLEEP_SEEN,
    input  wire logic                               HS_NEGOTIATED,
    input  wire usb_regs_pkg::ep0_evt_s             EP0_EVT,
    input  wire logic [1:0]                         OUT_EP_FLAGS,
    input  wire logic                               IN_EP_IRQ,
    input  wire logic [1:0][10:0]                   IN_LOADED_BYTES,
    input  wire logic [1:0]                         IN_DMA_WANT,
    input  wire logic [1:0]                         IN_PKT_SENT,
    input  wire logic [1:0]                         IN_ACK_SEEN,
    output usb_regs_pkg::ep0_ctl_s                  EP0_CTL,
    output usb_regs_pkg::in_ep_cfg_s [1:0]          IN_EP_CFG,
    output logic [1:0]                              IN_COMMIT,
    output logic [1:0]                              IN_DMA_REQ,
    output logic [1:0]                              IN_DATA_TOGGLE,
    output logic                                    HIGH_SPEED,
    output logic                                    TEST_PACKET_MODE,
    output logic                                    TEST_K_STATE,
    output logic                                    TEST_J_STATE,
    output logic                                    TEST_ZERO_NAK,
    output logic                                    IRQ
);
    logic                     rst_meta_q;
    logic                     rst_n_q;
    usb_regs_pkg::top_state_s q;
    usb_regs_pkg::top_state_s d;
    logic [7:0]               ep0_csr;
    logic                     ep0_wr;
    logic                     in_sel;
    logic                     idx;
    logic [7:0]               rd_val;
    logic [3:0]               bus_evt;

    // The release of reset is retimed so no flop leaves reset on a different edge.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Only endpoints 1 and 2 own IN configuration; index 0 holds endpoint 1.
    assign in_sel = (q.sel == usb_regs_pkg::EP_SEL_EP1) || (q.sel == usb_regs_pkg::EP_SEL_EP2);
    assign idx    = (q.sel == usb_regs_pkg::EP_SEL_EP2);
    assign ep0_wr = REG_WR && (REG_ADDR == usb_regs_pkg::ADDR_EP0_CSR)
                    && (q.sel == usb_regs_pkg::EP_SEL_EP0);
    assign bus_evt = {FRAME_START_SEEN, BUS_RESET_SEEN, RESUME_SEEN, SLEEP_SEEN};

    usb_ep0_csr u_ep0 (
        .clk   (CORE_CLK),
        .rst_n (rst_n_q),
        .wr    (ep0_wr),
        .wdata (REG_WDATA),
        .evt   (EP0_EVT),
        .csr   (ep0_csr),
        .ctl   (EP0_CTL)
    );

    // Read multiplexer; unmapped offsets and an empty window read as zero.
    always_comb begin
        rd_val = 8'h00;
        unique case (REG_ADDR)
            usb_regs_pkg::ADDR_OUT_IRQ_EN: rd_val = {5'h00, q.out_en, 1'b0};
            usb_regs_pkg::ADDR_BUS_IRQ_EN: rd_val = {4'h0, q.bus_en};
            usb_regs_pkg::ADDR_BUS_PEND:   rd_val = {4'h0, q.bus_pend};
            usb_regs_pkg::ADDR_FRAME_HI:   rd_val = {5'h00, q.frame[10:8]};
            usb_regs_pkg::ADDR_FRAME_LO:   rd_val = q.frame[7:0];
            usb_regs_pkg::ADDR_TEST:       rd_val = {2'b00, q.test};
            usb_regs_pkg::ADDR_EP_SEL:     rd_val = {6'h00, q.sel};
            usb_regs_pkg::ADDR_IN_MAXP_HI: begin
                if (in_sel) begin
                    rd_val = {5'h00, q.in_cfg[idx].max_payload[10:8]};
                end
            end
            usb_regs_pkg::ADDR_IN_MAXP_LO: begin
                if (in_sel) begin
                    rd_val = q.in_cfg[idx].max_payload[7:0];
                end
            end
            usb_regs_pkg::ADDR_IN_CTL_HI: begin
                // Endpoint 0 has no IN high control byte and reads zero.
                if (in_sel) begin
                    rd_val = {q.in_cfg[idx].auto_commit, 2'b00, q.in_cfg[idx].dma_en,
                              q.in_cfg[idx].force_toggle, 3'h0};
                end
            end
            usb_regs_pkg::ADDR_EP0_CSR: begin
                if (q.sel == usb_regs_pkg::EP_SEL_EP0) begin
                    rd_val = ep0_csr;
                end
            end
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        d        = q;
        d.commit = 2'b00;
        if (REG_RD) begin
            d.rdata = rd_val;
        end
        if (REG_WR) begin
            unique case (REG_ADDR)
                usb_regs_pkg::ADDR_OUT_IRQ_EN: begin
                    d.out_en = REG_WDATA[usb_regs_pkg::OUT_EN_EP2:usb_regs_pkg::OUT_EN_EP1];
                end
                usb_regs_pkg::ADDR_BUS_IRQ_EN: d.bus_en = REG_WDATA[3:0];
                usb_regs_pkg::ADDR_TEST:       d.test   = REG_WDATA[5:0];
                usb_regs_pkg::ADDR_EP_SEL:     d.sel    = usb_regs_pkg::ep_sel_e'(REG_WDATA[1:0]);
                usb_regs_pkg::ADDR_IN_MAXP_HI: begin
                    if (in_sel) begin
                        d.in_cfg[idx].max_payload[10:8] = REG_WDATA[2:0];
                    end
                end
                usb_regs_pkg::ADDR_IN_MAXP_LO: begin
                    if (in_sel) begin
                        d.in_cfg[idx].max_payload[7:0] = REG_WDATA;
                    end
                end
                usb_regs_pkg::ADDR_IN_CTL_HI: begin
                    if (in_sel) begin
                        d.in_cfg[idx].auto_commit  = REG_WDATA[usb_regs_pkg::INCTL_AUTO];
                        d.in_cfg[idx].dma_en       = REG_WDATA[usb_regs_pkg::INCTL_DMA];
                        d.in_cfg[idx].force_toggle = REG_WDATA[usb_regs_pkg::INCTL_FTOG];
                    end
                end
                default: ;
            endcase
        end
        // An event in the cycle of the clearing read stays pending for the next read.
        d.bus_pend = (REG_RD && REG_ADDR == usb_regs_pkg::ADDR_BUS_PEND) ? bus_evt
                     : (q.bus_pend | bus_evt);
        if (FRAME_START_SEEN) begin
            d.frame = FRAME_NUMBER_IN;
        end
        // Zero-NAK test holds high speed through bus resets; full speed wins if both are forced.
        if (BUS_RESET_SEEN && !q.test[usb_regs_pkg::TST_ZERO_NAK]) begin
            if (q.test[usb_regs_pkg::TST_FORCE_FS]) begin
                d.speed = usb_regs_pkg::SPD_FULL;
            end else if (q.test[usb_regs_pkg::TST_FORCE_HS]) begin
                d.speed = usb_regs_pkg::SPD_HIGH;
            end else begin
                d.speed = usb_regs_pkg::speed_e'(HS_NEGOTIATED);
            end
        end
        // Test signalling is only meaningful at high speed, so it is gated by the speed.
        d.test_out = q.test[3:0] & {4{q.speed == usb_regs_pkg::SPD_HIGH}};
        for (int i = 0; i < 2; i++) begin
            d.dma_req[i] = IN_DMA_WANT[i] && q.in_cfg[i].dma_en;
            d.at_max[i]  = (IN_LOADED_BYTES[i] == q.in_cfg[i].max_payload)
                           && (q.in_cfg[i].max_payload != 11'h000);
            d.commit[i]  = q.in_cfg[i].auto_commit && d.at_max[i] && !q.at_max[i];
            if (BUS_RESET_SEEN) begin
                d.toggle[i] = 1'b0;
            end else if (IN_PKT_SENT[i] && (IN_ACK_SEEN[i] || q.in_cfg[i].force_toggle)) begin
                d.toggle[i] = !q.toggle[i];
            end
        end
        d.irq = |(q.bus_pend & q.bus_en) || |(OUT_EP_FLAGS & q.out_en)
                || IN_EP_IRQ || EP0_CTL.irq_evt;
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            q        <= '0;
            q.out_en <= usb_regs_pkg::RST_OUT_IRQ_EN[2:1];
            q.bus_en <= usb_regs_pkg::RST_BUS_IRQ_EN[3:0];
            q.sel    <= usb_regs_pkg::EP_SEL_EP0;
            q.speed  <= usb_regs_pkg::SPD_FULL;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA        = q.rdata;
    assign IN_EP_CFG        = q.in_cfg;
    assign IN_COMMIT        = q.commit;
    assign IN_DMA_REQ       = q.dma_req;
    assign IN_DATA_TOGGLE   = q.toggle;
    assign HIGH_SPEED       = (q.speed == usb_regs_pkg::SPD_HIGH);
    assign TEST_PACKET_MODE = q.test_out[usb_regs_pkg::TST_PACKET];
    assign TEST_K_STATE     = q.test_out[usb_regs_pkg::TST_K];
    assign TEST_J_STATE     = q.test_out[usb_regs_pkg::TST_J];
    assign TEST_ZERO_NAK    = q.test_out[usb_regs_pkg::TST_ZERO_NAK];
    assign IRQ              = q.irq;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n_q);

    sequence s_pend_read;
        REG_RD && REG_ADDR == usb_regs_pkg::ADDR_BUS_PEND && !(|bus_evt);
    endsequence

    sequence s_forced_full_reset;
        BUS_RESET_SEEN && q.test[5] && !q.test[0];
    endsequence

    AST_PEND_CLEAR_ON_READ: assert property (
        s_pend_read |=> q.bus_pend == 4'h0 && REG_RDATA == {4'h0, $past(q.bus_pend)})
        else $error("bus pending flags not returned and cleared by read");
    AST_PEND_SET_WINS: assert property (
        FRAME_START_SEEN |=> q.bus_pend[3])
        else $error("frame start event lost");
    AST_FRAME_CAPTURE: assert property (
        FRAME_START_SEEN ##1 (REG_RD && REG_ADDR == 6'h0C && !FRAME_START_SEEN)
        |=> REG_RDATA == $past(FRAME_NUMBER_IN[7:0], 2))
        else $error("frame number low byte not captured");
    AST_FORCE_FULL: assert property (
        s_forced_full_reset |=> !HIGH_SPEED)
        else $error("forced full speed ignored on bus reset");
    AST_ZERO_NAK_HOLDS_HS: assert property (
        (q.test[0] && HIGH_SPEED && !(REG_WR && REG_ADDR == usb_regs_pkg::ADDR_TEST))
        |=> HIGH_SPEED ##1 TEST_ZERO_NAK)
        else $error("zero nak test left high speed");
    AST_TEST_NEEDS_HS: assert property (
        (TEST_K_STATE || TEST_J_STATE || TEST_PACKET_MODE) |-> $past(HIGH_SPEED))
        else $error("test signalling outside high speed");
    AST_EP0_CTL_HIGH_ZERO: assert property (
        (REG_RD && REG_ADDR == 6'h12 && q.sel == usb_regs_pkg::EP_SEL_EP0) |=> REG_RDATA == 8'h00)
        else $error("endpoint 0 high control byte not zero");
    AST_DMA_GATE: assert property (
        IN_DMA_REQ == ($past(IN_DMA_WANT)
                       & {$past(q.in_cfg[1].dma_en), $past(q.in_cfg[0].dma_en)}))
        else $error("dma request passed while disabled");
    AST_TOGGLE_FORCED: assert property (
        (IN_PKT_SENT[1] && !BUS_RESET_SEEN && q.in_cfg[1].force_toggle)
        |=> IN_DATA_TOGGLE[1] != $past(IN_DATA_TOGGLE[1]))
        else $error("forced toggle did not flip");
    AST_IRQ_FROM_PEND: assert property (
        (|(q.bus_pend & q.bus_en)) |=> IRQ)
        else $error("enabled pending flag raised no interrupt");
    AST_RESET_ENABLES: assert property (
        $rose(rst_n_q) |-> q.out_en == 2'b11 && q.bus_en == 4'h6)
        else $error("enable registers wrong after reset");
endmodule : usb_func_regs

// file: inc/usb_regs_pkg.sv
// Shared offsets, field positions, reset values and carrier types of the USB register block.
// Assumes an 8-bit CPU register port with a 6-bit byte address and single-cycle strobes.
package usb_regs_pkg;

    // Common registers.
    localparam logic [5:0] ADDR_OUT_IRQ_EN  = 6'h08;
    localparam logic [5:0] ADDR_BUS_IRQ_EN  = 6'h09;
    localparam logic [5:0] ADDR_BUS_PEND    = 6'h0A;
    localparam logic [5:0] ADDR_FRAME_HI    = 6'h0B;
    localparam logic [5:0] ADDR_FRAME_LO    = 6'h0C;
    localparam logic [5:0] ADDR_TEST        = 6'h0D;
    localparam logic [5:0] ADDR_EP_SEL      = 6'h0E;
    // Indexed window, 10h to 19h, steered by the endpoint select field.
    localparam logic [5:0] ADDR_IN_MAXP_HI  = 6'h10;
    localparam logic [5:0] ADDR_IN_MAXP_LO  = 6'h11;
    localparam logic [5:0] ADDR_IN_CTL_HI   = 6'h12;
    localparam logic [5:0] ADDR_EP0_CSR     = 6'h13;

    localparam logic [7:0] RST_OUT_IRQ_EN   = 8'h06;
    localparam logic [7:0] RST_BUS_IRQ_EN   = 8'h06;
    localparam logic [7:0] RST_ZERO         = 8'h00;

    // Field positions.
    localparam int OUT_EN_EP2      = 2;
    localparam int OUT_EN_EP1      = 1;
    localparam int BUS_FRAME_START = 3;
    localparam int BUS_RESET       = 2;
    localparam int BUS_RESUME      = 1;
    localparam int BUS_SLEEP       = 0;
    localparam int TST_FORCE_FS    = 5;
    localparam int TST_FORCE_HS    = 4;
    localparam int TST_PACKET      = 3;
    localparam int TST_K           = 2;
    localparam int TST_J           = 1;
    localparam int TST_ZERO_NAK    = 0;
    localparam int INCTL_AUTO      = 7;
    localparam int INCTL_DMA       = 4;
    localparam int INCTL_FTOG      = 3;
    localparam int EP0_CONTROL_STATUS_CLR_EARLY  = 7;
    localparam int EP0_CONTROL_STATUS_ACK_OUT    = 6;
    localparam int EP0_CONTROL_STATUS_SEND_STALL = 5;
    localparam int EP0_CONTROL_STATUS_EARLY      = 4;
    localparam int EP0_CONTROL_STATUS_DATA_END   = 3;
    localparam int EP0_CONTROL_STATUS_STALL_SENT = 2;
    localparam int EP0_CONTROL_STATUS_IN_READY   = 1;
    localparam int EP0_CONTROL_STATUS_OUT_READY  = 0;
    localparam int TEST_PKT_BYTES  = 53;

    typedef enum logic [1:0] {
        EP_SEL_EP0  = 2'b00,
        EP_SEL_EP1  = 2'b01,
        EP_SEL_EP2  = 2'b10,
        EP_SEL_NONE = 2'b11
    } ep_sel_e;

    typedef enum logic {
        SPD_FULL = 1'b0,
        SPD_HIGH = 1'b1
    } speed_e;

    // Events from the endpoint 0 protocol engine, each a one-cycle pulse.
    typedef struct packed {
        logic out_rx;
        logic in_sent;
        logic early_end;
        logic stall_tx;
        logic xfer_done;
    } ep0_evt_s;

    // Controls towards the endpoint 0 protocol engine.
    typedef struct packed {
        logic stall_req;
        logic data_end;
        logic in_ready;
        logic flush;
        logic irq_evt;
    } ep0_ctl_s;

    // Per IN endpoint configuration presented to the endpoint engine.
    typedef struct packed {
        logic [10:0] max_payload;
        logic        auto_commit;
        logic        dma_en;
        logic        force_toggle;
    } in_ep_cfg_s;

    typedef struct packed {
        logic send_stall;
        logic early_finish;
        logic data_end;
        logic stall_sent;
        logic in_ready;
        logic out_ready;
        logic flush;
        logic irq_evt;
    } ep0_state_s;

    typedef struct packed {
        logic [1:0]            out_en;
        logic [3:0]            bus_en;
        logic [3:0]            bus_pend;
        logic [10:0]           frame;
        logic [5:0]            test;
        ep_sel_e               sel;
        in_ep_cfg_s [1:0]      in_cfg;
        speed_e                speed;
        logic [3:0]            test_out;
        logic [7:0]            rdata;
        logic                  irq;
        logic [1:0]            commit;
        logic [1:0]            at_max;
        logic [1:0]            dma_req;
        logic [1:0]            toggle;
    } top_state_s;

endpackage : usb_regs_pkg

// file: logic/usb_ep0_csr.sv
// Endpoint 0 control/status byte with its set, clear and self-clearing bits.
// Assumes write strobes are already qualified by address and endpoint select.
module usb_ep0_csr (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     wr,
    input  wire logic [7:0]               wdata,
    input  wire usb_regs_pkg::ep0_evt_s   evt,
    output logic [7:0]                    csr,
    output usb_regs_pkg::ep0_ctl_s        ctl
);
    usb_regs_pkg::ep0_state_s q;
    usb_regs_pkg::ep0_state_s d;

    always_comb begin
        d         = q;
        d.flush   = 1'b0;
        d.irq_evt = 1'b0;
        // A new stall request in the same cycle as the previous stall going out is kept.
        if (evt.stall_tx) begin
            d.send_stall = 1'b0;
        end
        if (wr && wdata[usb_regs_pkg::EP0_CONTROL_STATUS_SEND_STALL]) begin
            d.send_stall = 1'b1;
        end
        if (wr && !wdata[usb_regs_pkg::EP0_CONTROL_STATUS_STALL_SENT]) begin
            d.stall_sent = 1'b0;
        end
        if (evt.stall_tx) begin
            d.stall_sent = 1'b1;
        end
        if (wr && wdata[usb_regs_pkg::EP0_CONTROL_STATUS_CLR_EARLY]) begin
            d.early_finish = 1'b0;
        end
        if (evt.early_end && !q.data_end) begin
            d.early_finish = 1'b1;
            d.flush        = 1'b1;
            d.irq_evt      = 1'b1;
        end
        if (evt.xfer_done) begin
            d.data_end = 1'b0;
        end
        if (wr && wdata[usb_regs_pkg::EP0_CONTROL_STATUS_DATA_END]) begin
            d.data_end = 1'b1;
        end
        if (evt.in_sent && q.in_ready) begin
            d.in_ready = 1'b0;
            d.irq_evt  = 1'b1;
        end
        if (wr && wdata[usb_regs_pkg::EP0_CONTROL_STATUS_IN_READY]) begin
            d.in_ready = 1'b1;
        end
        if (wr && wdata[usb_regs_pkg::EP0_CONTROL_STATUS_ACK_OUT]) begin
            d.out_ready = 1'b0;
        end
        if (evt.out_rx) begin
            d.out_ready = 1'b1;
            d.irq_evt   = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // The two service bits are strobes and always read back as zero.
    assign csr = {2'b00, q.send_stall, q.early_finish, q.data_end, q.stall_sent,
                  q.in_ready, q.out_ready};
    assign ctl = '{stall_req: q.send_stall, data_end: q.data_end, in_ready: q.in_ready,
                   flush: q.flush, irq_evt: q.irq_evt};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_OUT_READY_SET_WINS: assert property (
        evt.out_rx |=> q.out_ready && q.irq_evt)
        else $error("out packet ready lost on reception");
    AST_IN_READY_CLEAR_IRQ: assert property (
        (evt.in_sent && q.in_ready && !(wr && wdata[1])) |=> !q.in_ready && q.irq_evt)
        else $error("in packet ready not cleared with interrupt");
    AST_STALL_CYCLE: assert property (
        (q.send_stall && evt.stall_tx && !(wr && wdata[5])) |=> !q.send_stall && q.stall_sent)
        else $error("send stall not self cleared after stall sent");
    AST_EARLY_FLUSH: assert property (
        $rose(q.early_finish) |-> q.flush && q.irq_evt && csr[7:6] == 2'b00)
        else $error("early finish without flush and interrupt");
endmodule : usb_ep0_csr

// file: verification/usb_engine_model.sv
// Packet engine stand-in: turns one-cycle bench requests into registered event pulses.
// Assumes requests are driven at the falling edge of the core clock.
module usb_engine_model (
    input  wire logic                   clk,
    input  wire logic [8:0]             fire,
    input  wire logic [10:0]            fn_in,
    output usb_regs_pkg::ep0_evt_s      evt,
    output logic [3:0]                  bus_evt,
    output logic [10:0]                 fn
);
    timeunit 1ns;
    timeprecision 1ps;
    // The frame number is only valid beside a frame start, so it is inverted otherwise.
    always_ff @(posedge clk) begin
        {evt, bus_evt} <= fire;
        fn             <= fire[3] ? fn_in : ~fn_in;
    end
endmodule : usb_engine_model

// file: verification/usb_func_regs_tb.sv
// Register-level bench of the USB function register block.
// Assumes the engine model in its own file and strobes driven at the falling edge.
module usb_func_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, hs = 0;
    logic [5:0] addr = '0;
    logic [7:0] wd = '0, rdata;
    logic [8:0] fire = '0;
    logic [10:0] fni = '0, fn;
    logic [7:0] inx = '0;
    logic [1:0][10:0] loaded = '0;
    logic hspd, irq;
    logic [1:0] dreq, tog, com;
    wire [3:0] tm;
    usb_regs_pkg::ep0_ctl_s ctl;
    usb_regs_pkg::in_ep_cfg_s [1:0] cfg;
    logic [3:0] bev;
    usb_regs_pkg::ep0_evt_s evt;
    int err_total = 0, total_checks = 0;
    initial forever #2 clk = ~clk;
    usb_engine_model i_model (.clk(clk), .fire(fire), .fn_in(fni), .evt(evt), .bus_evt(bev),
        .fn(fn));
    usb_func_regs i_dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(rdata), .FRAME_START_SEEN(bev[3]),
        .FRAME_NUMBER_IN(fn), .BUS_RESET_SEEN(bev[2]), .RESUME_SEEN(bev[1]),
        .SLEEP_SEEN(bev[0]), .HS_NEGOTIATED(hs), .EP0_EVT(evt), .OUT_EP_FLAGS(inx[7:6]),
        .IN_EP_IRQ(1'b0), .IN_LOADED_BYTES(loaded), .IN_DMA_WANT(inx[1:0]),
        .IN_PKT_SENT(inx[3:2]), .IN_ACK_SEEN(inx[5:4]), .EP0_CTL(ctl), .IN_EP_CFG(cfg),
        .IN_COMMIT(com), .IN_DMA_REQ(dreq), .IN_DATA_TOGGLE(tog), .HIGH_SPEED(hspd),
        .TEST_PACKET_MODE(tm[3]), .TEST_K_STATE(tm[2]), .TEST_J_STATE(tm[1]),
        .TEST_ZERO_NAK(tm[0]), .IRQ(irq));
    task automatic final_report();
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask : wr_reg
    task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        chk(n, {3'h0, rdata}, {3'h0, e});
    endtask : rchk
    task automatic ev(input logic [8:0] f);
        @(negedge clk);
        fire = f;
        @(negedge clk);
        fire = '0;
        @(negedge clk);
    endtask : ev
    initial begin
        #20000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        rchk("out_en", 6'h08, 8'h06);
        rchk("bus_en", 6'h09, 8'h06);
        wr_reg(6'h08, 8'hFF);
        rchk("out_en_w", 6'h08, 8'h06);
        chk("irq_idle", irq, 11'h0);
        inx = 8'h80;
        @(negedge clk);
        inx = '0;
        chk("irq_out", irq, 11'h1);
        ev(9'h005);
        @(negedge clk);
        chk("irq", irq, 11'h1);
        rchk("pend", 6'h0A, 8'h05);
        rchk("pend_clr", 6'h0A, 8'h00);
        fni = 11'h5A3;
        @(negedge clk);
        fire = 9'h008;
        @(negedge clk);
        fire = '0;
        rchk("fn_lo", 6'h0C, 8'hA3);
        rchk("fn_hi", 6'h0B, 8'h05);
        hs = 1;
        wr_reg(6'h0D, 8'h20);
        ev(9'h004);
        @(negedge clk);
        chk("full", hspd, 11'h0);
        hs = 0;
        wr_reg(6'h0D, 8'h10);
        ev(9'h004);
        @(negedge clk);
        chk("high", hspd, 11'h1);
        wr_reg(6'h0D, 8'h14);
        @(negedge clk);
        chk("test_k", tm, 11'h4);
        wr_reg(6'h0D, 8'h01);
        ev(9'h004);
        chk("zero_nak", {hspd, tm}, 11'h11);
        wr_reg(6'h0D, 8'h0A); // The endpoint 0 buffer sits outside and counts as loaded.
        @(negedge clk);
        chk("test_pkt_j", tm, 11'h0A);
        wr_reg(6'h0E, 8'h02);
        wr_reg(6'h10, 8'hF9);
        wr_reg(6'h11, 8'h40);
        wr_reg(6'h12, 8'hFF);
        rchk("maxp_hi", 6'h10, 8'h01);
        rchk("maxp_lo", 6'h11, 8'h40);
        rchk("in_ctl_hi", 6'h12, 8'h98);
        chk("cfg_max", cfg[1].max_payload, 11'h140);
        loaded[1] = 11'h140;
        inx = 8'h0F;
        @(negedge clk);
        inx = '0;
        chk("commit", com, 11'h2);
        chk("dma_req", dreq, 11'h2);
        chk("toggle", tog, 11'h2);
        @(negedge clk);
        chk("commit_once", com, 11'h0);
        wr_reg(6'h0E, 8'h03);
        rchk("sel_none", 6'h10, 8'h00);
        wr_reg(6'h0E, 8'h00);
        rchk("ep0_ctl_hi", 6'h12, 8'h00);
        wr_reg(6'h13, 8'h02);
        rchk("in_rdy", 6'h13, 8'h02);
        ev(9'h080);
        rchk("in_sent", 6'h13, 8'h00);
        ev(9'h100);
        rchk("out_rdy", 6'h13, 8'h01);
        wr_reg(6'h13, 8'h40);
        rchk("out_ack", 6'h13, 8'h00);
        wr_reg(6'h13, 8'h20);
        rchk("stall_req", 6'h13, 8'h20);
        ev(9'h020);
        rchk("stall_sent", 6'h13, 8'h04);
        wr_reg(6'h13, 8'h00);
        rchk("stall_clr", 6'h13, 8'h00);
        wr_reg(6'h13, 8'h08);
        ev(9'h040);
        rchk("end_held", 6'h13, 8'h08);
        ev(9'h010);
        rchk("end_done", 6'h13, 8'h00);
        ev(9'h040);
        chk("flush", {ctl.flush, ctl.irq_evt}, 11'h3);
        rchk("early", 6'h13, 8'h10);
        wr_reg(6'h13, 8'h80);
        rchk("early_clr", 6'h13, 8'h00);
        final_report();
    end
endmodule : usb_func_regs_tb
